// file: design/phr_cipher.sv
module phr_cipher (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_start,
  input wire logic [6:0] i_off,
  input wire logic [6:0] i_len,
  input wire logic [127:0] i_key,
  input wire logic [7:0] i_rdata,
  output logic o_busy,
  output logic [6:0] o_idx,
  output logic o_we,
  output logic [7:0] o_wdata
);
  import phr_pkg::*;

  logic busy_ff, nxt_busy;
  logic [2:0] blk_ff, nxt_blk, nblk_ff, nxt_nblk;
  logic [8:0] cyc_ff, nxt_cyc;
  logic [6:0] off_ff, nxt_off, len_ff, nxt_len;
  logic [6:0] pos;

  // Keyed byte transform, one byte per cycle, block time padded out to the
  // fixed per-block latency; bytes past the message are read but never written back.
  assign pos = {blk_ff, cyc_ff[3:0]};
  assign o_busy = busy_ff;
  assign o_idx = off_ff + pos;
  assign o_we = busy_ff & (cyc_ff < {4'h0, CIPHER_BLOCK_BYTES}) & (pos < len_ff);
  assign o_wdata = i_rdata ^ i_key[{~cyc_ff[3:0], 3'h0} +: 8];

  always_comb begin
    nxt_busy = busy_ff;
    nxt_blk = blk_ff;
    nxt_nblk = nblk_ff;
    nxt_cyc = cyc_ff;
    nxt_off = off_ff;
    nxt_len = len_ff;
    if (i_start) begin
      nxt_busy = (i_len != 7'h00);
      nxt_blk = 3'h0;
      nxt_nblk = 3'((8'(i_len) + 8'h0f) >> 4);
      nxt_cyc = 9'h000;
      nxt_off = i_off;
      nxt_len = i_len;
    end else if (busy_ff) begin
      if (cyc_ff == CIPHER_BLOCK_CYC - 9'h001) begin
        nxt_cyc = 9'h000;
        nxt_blk = blk_ff + 3'h1;
        if (blk_ff == nblk_ff - 3'h1) begin
          nxt_busy = 1'b0;
        end
      end else begin
        nxt_cyc = cyc_ff + 9'h001;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      busy_ff <= 1'b0;
      blk_ff <= 3'h0;
      nblk_ff <= 3'h0;
      cyc_ff <= 9'h000;
      off_ff <= 7'h00;
      len_ff <= 7'h00;
    end else begin
      busy_ff <= nxt_busy;
      blk_ff <= nxt_blk;
      nblk_ff <= nxt_nblk;
      cyc_ff <= nxt_cyc;
      off_ff <= nxt_off;
      len_ff <= nxt_len;
    end
  end

endmodule

// file: design/phr_fifo.sv
module phr_fifo (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_push,
  input wire logic [7:0] i_push_data,
  input wire logic i_pop,
  input wire logic i_flush,
  input wire logic [6:0] i_idx,
  input wire logic i_we,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_head,
  output logic [7:0] o_rdata,
  output logic [6:0] o_count
);
  import phr_pkg::*;

  logic [7:0] mem [FIFO_DEPTH];
  logic [6:0] wr_ff, rd_ff, cnt_ff;
  logic [6:0] nxt_wr, nxt_rd, nxt_cnt;
  logic do_push, do_pop;
  logic [6:0] side_addr;

  function automatic logic [6:0] wrap(input logic [7:0] p);
    wrap = (p >= {1'b0, FIFO_DEPTH}) ? 7'(p - {1'b0, FIFO_DEPTH}) : p[6:0];
  endfunction

  // Random access relative to the head, used for in-place ciphering
  assign side_addr = wrap({1'b0, rd_ff} + {1'b0, i_idx});
  assign do_push = i_push & (cnt_ff != FIFO_DEPTH);
  assign do_pop = i_pop & (cnt_ff != 7'h00);
  assign o_head = mem[rd_ff];
  assign o_rdata = mem[side_addr];
  assign o_count = cnt_ff;

  always_comb begin
    nxt_wr = do_push ? wrap({1'b0, wr_ff} + 8'h01) : wr_ff;
    nxt_rd = do_pop ? wrap({1'b0, rd_ff} + 8'h01) : rd_ff;
    nxt_cnt = cnt_ff + {6'h00, do_push} - {6'h00, do_pop};
    if (i_flush) begin
      nxt_wr = 7'h00;
      nxt_rd = 7'h00;
      nxt_cnt = 7'h00;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      wr_ff <= 7'h00;
      rd_ff <= 7'h00;
      cnt_ff <= 7'h00;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  // Storage is not reset: contents are only meaningful below the count
  always_ff @(posedge i_sys_clk) begin
    if (do_push && !i_flush) begin
      mem[wr_ff] <= i_push_data;
    end
    if (i_we) begin
      mem[side_addr] <= i_wdata;
    end
  end

endmodule

// file: design/phr_pkg.sv
package phr_pkg;

  localparam logic [6:0] FIFO_DEPTH = 7'h42;
  localparam int SYS_CLK_KHZ = 50000;
  localparam int CIPHER_BLOCK_NS = 7000;
  localparam int CIPHER_BLOCK_CYC_INT = CIPHER_BLOCK_NS * SYS_CLK_KHZ / 1000000;
  localparam logic [8:0] CIPHER_BLOCK_CYC = 9'(CIPHER_BLOCK_CYC_INT);
  localparam logic [4:0] CIPHER_BLOCK_BYTES = 5'h10;
  localparam logic [7:0] PREAMBLE_BYTE = 8'haa;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_SEED = 16'h1d0f;
  localparam logic [8:0] WHITE_SEED = 9'h1ff;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [1:0] DCF_MANCH = 2'h1;
  localparam logic [1:0] DCF_WHITE = 2'h2;
  localparam logic [1:0] MATCH_OFF = 2'h0;

  typedef enum logic [1:0] {
    MODE_SLEEP = 2'h0,
    MODE_STBY = 2'h1,
    MODE_TX = 2'h2,
    MODE_RX = 2'h3
  } phr_mode_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CIPH = 3'h1,
    ST_PRE = 3'h3,
    ST_SYNC = 3'h2,
    ST_BODY = 3'h6,
    ST_CRC = 3'h7,
    ST_DONE = 3'h5
  } phr_state_type;

  typedef struct packed {
    phr_mode_type mode;
    logic frame_format_select;
    logic [7:0] body_len_setting;
    logic send_trigger_select;
    logic sync_detect_enable;
    logic buffer_fill_rule;
    logic [6:0] buffer_level_setting;
    logic [7:0] station_id_value;
    logic [1:0] station_match_mode;
    logic checksum_enable;
    logic keep_on_checksum_fail;
    logic [1:0] line_balance_select;
    logic [7:0] preamble_len;
    logic [15:0] sync_word;
    logic cipher_enable;
  } phr_cfg_type;

  typedef struct packed {
    logic checksum_good_flag;
    logic rx_body_complete_flag;
    logic buffer_level_flag;
    logic buffer_full_flag;
    logic buffer_has_data_flag;
    logic tx_done_flag;
  } phr_status_type;

endpackage

// file: design/phr_radio_packet_handler.sv
module phr_radio_packet_handler (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire phr_pkg::phr_cfg_type i_cfg,
  input wire logic i_key_wr,
  input wire logic [127:0] i_key,
  input wire logic i_host_wr_valid,
  input wire logic [7:0] i_host_wr_data,
  output logic o_host_wr_ready,
  input wire logic i_host_rd_req,
  output logic [7:0] o_host_rd_data,
  output logic o_host_rd_valid,
  input wire logic i_link_clk,
  input wire logic i_rx_line,
  output logic o_tx_line,
  output phr_pkg::phr_status_type o_status,
  output logic o_flag_pin_zero
);
  import phr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic link_s1_ff, link_s2_ff, link_s3_ff, rx_s1_ff, rx_s2_ff;
  phr_state_type st_ff, nxt_st;
  phr_mode_type mode_ff;
  logic [15:0] sh_ff, nxt_sh, crc_ff, nxt_crc;
  logic [4:0] bit_ff, nxt_bit;
  logic [7:0] byte_ff, nxt_byte;
  logic [8:0] len_ff, nxt_len, new_len;
  logic [8:0] lfsr_ff, nxt_lfsr;
  logic half_ff, nxt_half, tx_ff, nxt_tx;
  logic good_ff, nxt_good, rxd_ff, nxt_rxd, txd_ff, nxt_txd;
  logic [127:0] key_ff, nxt_key;
  logic [7:0] rd_data_ff, nxt_rd_data;
  logic rd_valid_ff;
  logic rise, is_tx, is_rx, unlimited, raw, man, wht, manc, addr_on, start_ok;
  logic tx_w, rx_b, rx_d, rx_take, bad_len, bad_addr;
  logic tx_pop, rx_push, host_push, host_pop, flush, launch, body_init, rx_finish;
  logic [7:0] rx_byte, fifo_head, fifo_rdata;
  logic [6:0] fifo_count, msg_off, cip_len, cip_idx;
  logic cip_start, cip_busy, cip_we;
  logic [7:0] cip_wdata;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic d);
    crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ d) ? CRC_POLY : 16'h0000);
  endfunction

  function automatic logic [8:0] lfsr_step(input logic [8:0] l);
    lfsr_step = {l[0] ^ l[5], l[8:1]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link clock and data come from the modem domain
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      link_s1_ff <= 1'b0;
      link_s2_ff <= 1'b0;
      link_s3_ff <= 1'b0;
      rx_s1_ff <= 1'b0;
      rx_s2_ff <= 1'b0;
    end else begin
      link_s1_ff <= i_link_clk;
      link_s2_ff <= link_s1_ff;
      link_s3_ff <= link_s2_ff;
      rx_s1_ff <= i_rx_line;
      rx_s2_ff <= rx_s1_ff;
    end
  end

  assign rise = link_s2_ff & ~link_s3_ff;
  assign is_tx = (i_cfg.mode == MODE_TX);
  assign is_rx = (i_cfg.mode == MODE_RX);
  assign unlimited = ~i_cfg.frame_format_select & (i_cfg.body_len_setting == 8'h00);
  assign raw = unlimited & ~i_cfg.sync_detect_enable;
  assign man = (i_cfg.line_balance_select == DCF_MANCH) & ~raw;
  assign wht = (i_cfg.line_balance_select == DCF_WHITE) & ~raw;
  assign manc = man & ((st_ff == ST_BODY) | (st_ff == ST_CRC));
  assign addr_on = (i_cfg.station_match_mode != MATCH_OFF) & ~raw;
  assign msg_off = {6'h00, i_cfg.frame_format_select} + {6'h00, addr_on};
  assign start_ok = i_cfg.send_trigger_select ? (fifo_count != 7'h00)
                                              : (fifo_count > i_cfg.buffer_level_setting);
  assign tx_w = sh_ff[15] ^ (wht & lfsr_ff[0]);
  assign rx_b = rx_s2_ff;
  assign rx_d = rx_b ^ (wht & lfsr_ff[0]);
  // Manchester: the first chip of a pair carries the bit
  assign rx_take = rise & (~manc | ~half_ff);
  assign rx_byte = {sh_ff[6:0], rx_d};
  assign bad_len = i_cfg.frame_format_select & (byte_ff == 8'h00)
                   & (rx_byte > i_cfg.body_len_setting);
  assign bad_addr = addr_on & (byte_ff == {7'h00, i_cfg.frame_format_select})
                    & (rx_byte != i_cfg.station_id_value);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st = st_ff;
    nxt_sh = sh_ff;
    nxt_bit = bit_ff;
    nxt_byte = byte_ff;
    nxt_len = len_ff;
    nxt_half = half_ff;
    nxt_crc = crc_ff;
    nxt_lfsr = lfsr_ff;
    nxt_tx = tx_ff;
    nxt_good = good_ff;
    nxt_rxd = rxd_ff;
    nxt_txd = txd_ff;
    new_len = 9'h000;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    flush = 1'b0;
    launch = 1'b0;
    body_init = 1'b0;
    rx_finish = 1'b0;
    if ((mode_ff != i_cfg.mode) || !(is_tx || is_rx)) begin
      nxt_st = ST_IDLE;
      nxt_tx = 1'b0;
    end else if (is_tx) begin
      unique case (st_ff)
        ST_IDLE: begin
          nxt_txd = 1'b0;
          if (rise) begin
            nxt_tx = (i_cfg.preamble_len != 8'h00) & ~tx_ff;
          end
          if (start_ok) begin
            if (i_cfg.cipher_enable) begin
              nxt_st = ST_CIPH;
            end else begin
              launch = 1'b1;
            end
          end
        end
        ST_CIPH: begin
          if (!cip_busy) begin
            launch = 1'b1;
          end
        end
        ST_PRE, ST_SYNC: begin
          if (rise) begin
            nxt_tx = sh_ff[15];
            nxt_sh = {sh_ff[14:0], 1'b0};
            nxt_bit = bit_ff - 5'h01;
            if (bit_ff == 5'h01) begin
              if (st_ff == ST_SYNC) begin
                body_init = 1'b1;
              end else if (byte_ff == i_cfg.preamble_len - 8'h01) begin
                nxt_st = ST_SYNC;
                nxt_sh = i_cfg.sync_word;
                nxt_bit = WORD_BITS;
              end else begin
                nxt_sh = {PREAMBLE_BYTE, 8'h00};
                nxt_bit = BYTE_BITS;
                nxt_byte = byte_ff + 8'h01;
              end
            end
          end
        end
        ST_BODY, ST_CRC: begin
          if (bit_ff == 5'h00) begin
            if (fifo_count != 7'h00) begin
              tx_pop = 1'b1;
              nxt_sh = {fifo_head, 8'h00};
              nxt_bit = BYTE_BITS;
              if (i_cfg.frame_format_select && byte_ff == 8'h00) begin
                nxt_len = {1'b0, fifo_head} + 9'h001;
              end
            end else if (unlimited) begin
              nxt_st = ST_DONE;
              // Buffer ran dry: the checksum still closes an unlimited packet
              if (i_cfg.checksum_enable) begin
                nxt_st = ST_CRC;
                nxt_sh = crc_ff;
                nxt_bit = WORD_BITS;
              end
            end
          end else if (rise) begin
            nxt_tx = (manc & half_ff) ? ~tx_w : tx_w;
            nxt_half = manc & ~half_ff;
            if (!manc || half_ff) begin
              nxt_sh = {sh_ff[14:0], 1'b0};
              nxt_bit = bit_ff - 5'h01;
              nxt_lfsr = wht ? lfsr_step(lfsr_ff) : lfsr_ff;
              if (st_ff == ST_BODY) begin
                nxt_crc = crc_step(crc_ff, sh_ff[15]);
              end
              if (bit_ff == 5'h01) begin
                if (st_ff == ST_CRC) begin
                  nxt_st = ST_DONE;
                end else begin
                  nxt_byte = byte_ff + 8'h01;
                  nxt_len = len_ff - 9'h001;
                  if (!unlimited && len_ff == 9'h001) begin
                    if (i_cfg.checksum_enable) begin
                      nxt_st = ST_CRC;
                      nxt_sh = crc_step(crc_ff, sh_ff[15]);
                      nxt_bit = WORD_BITS;
                    end else begin
                      nxt_st = ST_DONE;
                    end
                  end
                end
              end
            end
          end
        end
        ST_DONE: begin
          // Last chip keeps its full slot before the line drops
          if (rise) begin
            nxt_tx = 1'b0;
            nxt_txd = 1'b1;
          end
        end
        default: begin
          nxt_st = ST_IDLE;
        end
      endcase
    end else begin
      unique case (st_ff)
        ST_IDLE: begin
          nxt_good = 1'b0;
          nxt_rxd = 1'b0;
          nxt_sh = 16'h0000;
          if (raw && i_cfg.buffer_fill_rule) begin
            body_init = 1'b1;
          end else begin
            nxt_st = ST_SYNC;
          end
        end
        ST_SYNC: begin
          if (rise) begin
            nxt_sh = {sh_ff[14:0], rx_b};
            if ((i_cfg.sync_detect_enable && {sh_ff[14:0], rx_b} == i_cfg.sync_word)
                || (!i_cfg.sync_detect_enable && i_cfg.buffer_fill_rule)) begin
              body_init = 1'b1;
            end
          end
        end
        ST_BODY, ST_CRC: begin
          if (rise && manc) begin
            nxt_half = ~half_ff;
          end
          if (rx_take) begin
            nxt_sh = {sh_ff[14:0], rx_d};
            nxt_bit = bit_ff + 5'h01;
            nxt_lfsr = wht ? lfsr_step(lfsr_ff) : lfsr_ff;
            if (st_ff == ST_BODY) begin
              nxt_crc = crc_step(crc_ff, rx_d);
              if (bit_ff == BYTE_BITS - 5'h01) begin
                nxt_bit = 5'h00;
                if (bad_len || bad_addr) begin
                  flush = 1'b1;
                  nxt_st = ST_SYNC;
                end else begin
                  rx_push = 1'b1;
                  nxt_byte = byte_ff + 8'h01;
                  new_len = (i_cfg.frame_format_select && byte_ff == 8'h00)
                            ? {1'b0, rx_byte} : len_ff - 9'h001;
                  nxt_len = new_len;
                  if (!unlimited && new_len == 9'h000) begin
                    if (i_cfg.checksum_enable) begin
                      nxt_st = ST_CRC;
                    end else begin
                      rx_finish = 1'b1;
                    end
                  end
                end
              end
            end else if (bit_ff == WORD_BITS - 5'h01) begin
              // Trailing CRC bytes are compared, never pushed
              if ({sh_ff[14:0], rx_d} == crc_ff) begin
                nxt_good = 1'b1;
                rx_finish = 1'b1;
              end else if (i_cfg.keep_on_checksum_fail) begin
                rx_finish = 1'b1;
              end else begin
                flush = 1'b1;
                nxt_st = ST_SYNC;
              end
            end
          end
        end
        ST_CIPH: begin
          if (!cip_busy) begin
            nxt_st = ST_DONE;
          end
        end
        ST_DONE: begin
          nxt_rxd = 1'b1;
        end
        default: begin
          nxt_st = ST_IDLE;
        end
      endcase
    end
    if (rx_finish) begin
      nxt_st = i_cfg.cipher_enable ? ST_CIPH : ST_DONE;
    end
    if (launch) begin
      nxt_byte = 8'h00;
      if (i_cfg.preamble_len != 8'h00) begin
        nxt_st = ST_PRE;
        nxt_sh = {PREAMBLE_BYTE, 8'h00};
        nxt_bit = BYTE_BITS;
      end else begin
        nxt_st = ST_SYNC;
        nxt_sh = i_cfg.sync_word;
        nxt_bit = WORD_BITS;
      end
    end
    if (body_init) begin
      nxt_st = ST_BODY;
      nxt_bit = 5'h00;
      nxt_byte = 8'h00;
      nxt_len = i_cfg.frame_format_select ? 9'h001 : {1'b0, i_cfg.body_len_setting};
      nxt_crc = CRC_SEED;
      nxt_lfsr = WHITE_SEED;
      nxt_half = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      st_ff <= ST_IDLE;
      mode_ff <= MODE_SLEEP;
      sh_ff <= 16'h0000;
      bit_ff <= 5'h00;
      byte_ff <= 8'h00;
      len_ff <= 9'h000;
      half_ff <= 1'b0;
      crc_ff <= CRC_SEED;
      lfsr_ff <= WHITE_SEED;
      tx_ff <= 1'b0;
      good_ff <= 1'b0;
      rxd_ff <= 1'b0;
      txd_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      mode_ff <= i_cfg.mode;
      sh_ff <= nxt_sh;
      bit_ff <= nxt_bit;
      byte_ff <= nxt_byte;
      len_ff <= nxt_len;
      half_ff <= nxt_half;
      crc_ff <= nxt_crc;
      lfsr_ff <= nxt_lfsr;
      tx_ff <= nxt_tx;
      good_ff <= nxt_good;
      rxd_ff <= nxt_rxd;
      txd_ff <= nxt_txd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host side: buffer closed to the host while the cipher owns it
  assign o_host_wr_ready = (fifo_count != FIFO_DEPTH) & ~is_rx & (st_ff != ST_CIPH);
  assign host_push = i_host_wr_valid & o_host_wr_ready;
  assign host_pop = i_host_rd_req & (fifo_count != 7'h00) & ~is_tx & (st_ff != ST_CIPH);

  always_comb begin
    nxt_key = i_key_wr ? i_key : key_ff;
    nxt_rd_data = host_pop ? fifo_head : rd_data_ff;
  end

  // Key has no read path and no mode touches it
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      key_ff <= 128'h0;
      rd_data_ff <= 8'h00;
      rd_valid_ff <= 1'b0;
    end else begin
      key_ff <= nxt_key;
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= host_pop;
    end
  end

  assign o_host_rd_data = rd_data_ff;
  assign o_host_rd_valid = rd_valid_ff;
  assign o_tx_line = tx_ff;
  assign o_status = '{checksum_good_flag: good_ff,
                      rx_body_complete_flag: rxd_ff,
                      buffer_level_flag: fifo_count > i_cfg.buffer_level_setting,
                      buffer_full_flag: fifo_count == FIFO_DEPTH,
                      buffer_has_data_flag: fifo_count != 7'h00,
                      tx_done_flag: txd_ff};
  assign o_flag_pin_zero = is_tx ? txd_ff : rxd_ff;

  ////////////////////////////////////////////////////////////////////////////
  assign cip_start = (st_ff != ST_CIPH) & (nxt_st == ST_CIPH);
  // Receive takes the next byte count, so a byte finishing in the same cycle is included; transmit takes the current fifo count
  assign cip_len = is_tx ? (fifo_count - msg_off) : (nxt_byte[6:0] - msg_off);

  phr_fifo u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_push(is_rx ? rx_push : host_push),
    .i_push_data(is_rx ? rx_byte : i_host_wr_data),
    .i_pop(tx_pop | host_pop),
    .i_flush(flush),
    .i_idx(cip_idx),
    .i_we(cip_we),
    .i_wdata(cip_wdata),
    .o_head(fifo_head),
    .o_rdata(fifo_rdata),
    .o_count(fifo_count)
  );

  phr_cipher u_cipher (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_start(cip_start),
    .i_off(msg_off),
    .i_len(cip_len),
    .i_key(key_ff),
    .i_rdata(fifo_rdata),
    .o_busy(cip_busy),
    .o_idx(cip_idx),
    .o_we(cip_we),
    .o_wdata(cip_wdata)
  );

endmodule

// file: test/phr_modem_model.sv
module phr_modem_model (
  input wire logic i_run,
  input wire logic i_tx_line,
  output logic o_link_clk,
  output logic o_rx_line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [63:0] tx_hist = '0;
  logic busy = 1'h0;
  initial begin
    o_link_clk = 1'h0;
    o_rx_line = 1'h0;
    #3;
    forever begin
      #80;
      o_link_clk = i_run ? ~o_link_clk : 1'h0;
    end
  end
  // Idle line wanders so a stale chip never passes for data
  always @(negedge o_link_clk) if (!busy) o_rx_line <= ~o_rx_line;
  always @(posedge o_link_clk) tx_hist <= {tx_hist[62:0], i_tx_line};
  task automatic send(input logic [7:0] b);
    busy = 1'h1;
    for (int i = 7; i >= 0; i--) begin
      @(negedge o_link_clk);
      o_rx_line <= b[i];
    end
  endtask
endmodule

// file: test/phr_radio_packet_handler_props.sv
module phr_radio_packet_handler_props (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire phr_pkg::phr_cfg_type i_cfg,
  input wire logic i_host_wr_valid,
  input wire logic o_host_wr_ready,
  input wire logic i_host_rd_req,
  input wire logic o_host_rd_valid,
  input wire phr_pkg::phr_status_type o_status,
  input wire logic o_flag_pin_zero
);
  timeunit 1ns;
  timeprecision 1ns;
  import phr_pkg::*;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  AST_PIN_ZERO: assert property (
    o_flag_pin_zero == (i_cfg.mode == MODE_TX ? o_status.tx_done_flag
      : o_status.rx_body_complete_flag)) else $error("pin zero mismatch");
  AST_UNLIM_NO_FLAGS: assert property (
    (i_cfg.mode == MODE_RX && !i_cfg.frame_format_select && i_cfg.body_len_setting == 8'h0)[*6]
    |-> !o_status.checksum_good_flag && !o_status.rx_body_complete_flag)
    else $error("flag in unlimited receive");
  AST_RX_NO_WRITE: assert property (
    i_cfg.mode == MODE_RX |-> !o_host_wr_ready) else $error("write open in receive");
  AST_FULL_REFUSE: assert property (
    o_status.buffer_full_flag |-> !o_host_wr_ready) else $error("write open when full");
  AST_WR_LANDS: assert property (
    i_cfg.mode == MODE_STBY && i_host_wr_valid && o_host_wr_ready
    |=> o_status.buffer_has_data_flag) else $error("written byte missing");
  AST_RD_ANSWER: assert property (
    (i_cfg.mode == MODE_STBY)[*2] ##0 i_host_rd_req && o_status.buffer_has_data_flag
    |=> o_host_rd_valid) else $error("read not answered");
  AST_RD_CAUSE: assert property (
    o_host_rd_valid |-> $past(i_host_rd_req) && $past(o_status.buffer_has_data_flag))
    else $error("read answer without request");
  AST_LEVEL_DATA: assert property (
    o_status.buffer_level_flag |-> o_status.buffer_has_data_flag)
    else $error("level flag on empty buffer");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind phr_radio_packet_handler phr_radio_packet_handler_props phr_radio_packet_handler_props_inst (
  .i_sys_clk, .i_rstn, .i_cfg, .i_host_wr_valid, .o_host_wr_ready, .i_host_rd_req,
  .o_host_rd_valid, .o_status, .o_flag_pin_zero);

// file: test/test_phr_radio_packet_handler.sv
module test_phr_radio_packet_handler;
  timeunit 1ns;
  timeprecision 1ns;
  import phr_pkg::*;
  localparam logic [15:0] SYNC = 16'h2dd4;
  logic i_sys_clk, i_rstn, wr_v, rd_req, lclk, rx, tx, rd_v, wr_rdy, pin0, hit;
  logic [7:0] wr_d, rd_d, b1;
  logic [7:0] exp_q[$];
  logic [7:0] wq[$];
  phr_cfg_type cfg;
  phr_status_type st;
  int errors = 0;
  int checked = 0;
  int n;
  phr_radio_packet_handler phr_radio_packet_handler_inst (.i_sys_clk, .i_rstn, .i_cfg(cfg),
    .i_key_wr(1'h0), .i_key(128'h0), .i_host_wr_valid(wr_v), .i_host_wr_data(wr_d),
    .o_host_wr_ready(wr_rdy), .i_host_rd_req(rd_req), .o_host_rd_data(rd_d),
    .o_host_rd_valid(rd_v), .i_link_clk(lclk), .i_rx_line(rx), .o_tx_line(tx),
    .o_status(st), .o_flag_pin_zero(pin0));
  phr_modem_model phr_modem_model_inst (.i_run(cfg.mode[1]), .i_tx_line(tx),
    .o_link_clk(lclk), .o_rx_line(rx));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("Checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge i_sys_clk);
    #2;
  endtask
  task automatic push(input logic [7:0] b);
    int w;
    wr_v = 1'h1;
    wr_d = b;
    for (w = 0; w < 50 && wr_rdy !== 1'h1; w++) step(1);
    if (w == 50) begin
      errors++;
      print_verdict();
    end
    step(1);
    wr_v = 1'h0;
    step(1);
  endtask
  task automatic pop(input logic [7:0] e);
    exp_q.push_back(e);
    rd_req = 1'h1;
    step(1);
    rd_req = 1'h0;
    step(1);
  endtask
  // CCITT over the payload bytes only, MSB first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction
  task automatic frame(input logic [7:0] a, input logic [7:0] d);
    logic [15:0] c;
    c = crc_byte(crc_byte(CRC_SEED, a), d);
    phr_modem_model_inst.send(8'haa);
    phr_modem_model_inst.send(8'haa);
    phr_modem_model_inst.send(SYNC[15:8]);
    phr_modem_model_inst.send(SYNC[7:0]);
    phr_modem_model_inst.send(a);
    phr_modem_model_inst.send(d);
    phr_modem_model_inst.send(c[15:8]);
    phr_modem_model_inst.send(c[7:0]);
    phr_modem_model_inst.busy = 1'h0;
  endtask
  always @(posedge i_sys_clk) if (rd_v) check("rd", 16'(rd_d), 16'(exp_q.pop_front()));
  initial begin
    i_sys_clk = 1'h0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  // Guard against a stalled link model
  initial begin
    #1000000;
    errors++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h12bda673));
    cfg = '0;
    cfg.mode = MODE_STBY;
    cfg.sync_word = SYNC;
    cfg.preamble_len = 8'h02;
    cfg.body_len_setting = 8'h02;
    cfg.send_trigger_select = 1'h1;
    cfg.sync_detect_enable = 1'h1;
    i_rstn = 1'h0;
    wr_v = 1'h0;
    rd_req = 1'h0;
    wr_d = 8'h0;
    step(4);
    i_rstn = 1'h1;
    check("idle", 16'({wr_rdy, st}), 16'h40);
    for (int i = 0; i < 66; i++) begin
      wq.push_back(8'($urandom()));
      push(wq[i]);
    end
    check("full", 16'({st.buffer_level_flag, st.buffer_full_flag, wr_rdy}), 16'h6);
    foreach (wq[i]) pop(wq[i]);
    b1 = 8'($urandom());
    push(8'h5a);
    push(b1);
    cfg.mode = MODE_TX;
    for (n = 0; n < 5000 && st.tx_done_flag !== 1'h1; n++) step(1);
    if (n == 5000) begin
      errors++;
      print_verdict();
    end
    step(40);
    // Chip alignment against the capture is loose, so slide over the history
    hit = 1'h0;
    for (int i = 0; i <= 32; i++) hit |= phr_modem_model_inst.tx_hist[i +: 32] == {SYNC, 8'h5a, b1};
    check("tx", 16'(hit), 16'h1);
    check("sent", 16'({st.tx_done_flag, pin0}), 16'h3);
    cfg.mode = MODE_STBY;
    cfg.station_id_value = 8'h5a;
    cfg.station_match_mode = 2'h1;
    cfg.checksum_enable = 1'h1;
    cfg.cipher_enable = 1'h1;
    for (int k = 0; k < 2; k++) begin
      cfg.mode = MODE_RX;
      step(2);
      frame(k == 0 ? 8'h5a : 8'h5b, b1);
      step(40);
      check("good", 16'(st.checksum_good_flag), 16'(k == 0));
      check("early", 16'(st.rx_body_complete_flag), 16'h0);
      step(400);
      check("done", 16'(st.rx_body_complete_flag), 16'(k == 0));
      cfg.mode = MODE_STBY;
      step(2);
      if (k == 0) begin
        pop(8'h5a);
        pop(b1);
      end
      check("empty", 16'(st.buffer_has_data_flag), 16'h0);
    end
    cfg.body_len_setting = 8'h0;
    cfg.sync_detect_enable = 1'h0;
    cfg.buffer_fill_rule = 1'h1;
    cfg.mode = MODE_RX;
    step(2);
    frame(8'h12, 8'h34);
    check("raw", 16'({st.buffer_has_data_flag, st.rx_body_complete_flag}), 16'h2);
    print_verdict();
  end
endmodule
